// >>> bench/sdg_link_sva.sv
// link wire checks for the host and device pair
`timescale 1ns/1ps
`default_nettype none
module sdg_link_sva (
    // system
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // link
    input wire logic sclk,
    input wire logic chip_select_low,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    logic sclk_q;
    logic [6:0] rise_q;
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    // previous link clock level for edge finding
    always_ff @(posedge i_clock) begin
        sclk_q <= sclk;
    end
    // rises per frame, cleared while deselected
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || chip_select_low) begin
            rise_q <= 7'h00;
        end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 7'h01;
        end
    end
    sequence s_open;
        $fell(chip_select_low);
    endsequence
    sequence s_msb_low;
        ##4 (miso_oe && !miso_o);
    endsequence
    a_status_msb: assert property (s_open |-> s_msb_low)
        else $error("status msb not low");
    a_oe_off: assert property (chip_select_low [*4] |-> !miso_oe)
        else $error("miso driven while idle");
    a_idle_high: assert property (chip_select_low |-> sclk)
        else $error("link clock low while idle");
    a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*3])
        else $error("link clock half period short");
    a_frame_len: assert property ($rose(chip_select_low) |-> rise_q == 7'h28)
        else $error("frame not forty clocks");
    a_mosi_hold: assert property ($rose(sclk) |-> $stable(mosi) ##1 $stable(mosi))
        else $error("mosi moved at sample edge");
    a_miso_hold: assert property ($rose(sclk) |=> (!miso_oe || $stable(miso_o)) [*3])
        else $error("miso moved while clock high");
    a_cs_gap: assert property ($rose(chip_select_low) |=> chip_select_low [*3])
        else $error("deselect gap short");
endmodule
`default_nettype wire

// >>> bench/spi_datagram_slave_tb_top.sv
// bench: host and device on one link, a hand-driven second device
`timescale 1ns/1ps
`default_nettype none
module spi_datagram_slave_tb_top;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [1:0] h_addr = 2'h0;
    logic [31:0] h_wdata = 32'h0000_0000;
    logic h_wr = 1'b0;
    logic h_rd = 1'b0;
    logic [3:0] lv = 4'h0;
    logic [2:0] ev = 3'h0;
    logic [31:0] seed = 32'h2C697B8B;
    logic [31:0] h_rdata;
    wire [1:0] rq_v;
    wire [1:0] rq_w;
    wire [6:0] rq_a [2];
    wire [31:0] rq_d [2];
    wire [7:0] sb [2];
    int error_cnt = 0;
    int check_count = 0;
    // register stand-in: read data made from the address
    function automatic logic [31:0] rdv(input logic [6:0] a);
        return {4{1'b0, a}};
    endfunction
    sdg_if i_sdg_if [2] ();
    sdg_host i_sdg_host (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(h_addr),
        .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata), .link(i_sdg_if[0]));
    // device 0 faces the host, device 1 the hand driver
    for (genvar g = 0; g < 2; g++) begin : g_dev
        int n = 0;
        sdg_device i_sdg_device (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(i_sdg_if[g]),
            .o_req_valid(rq_v[g]), .o_req_write(rq_w[g]), .o_req_addr(rq_a[g]),
            .o_req_wdata(rq_d[g]), .i_rdata(rdv(rq_a[g])), .i_stop_left_axis_one(lv[2]),
            .i_stop_left_axis_two(lv[3]), .i_vel_reached_axis_one(lv[0]),
            .i_vel_reached_axis_two(lv[1]), .i_drv_err_axis_one(ev[1]),
            .i_drv_err_axis_two(ev[2]), .i_reset_event(ev[0]), .o_link_status_byte(sb[g]));
        // requests counted as they leave
        always @(posedge i_clock) begin
            if (rq_v[g] === 1'b1) n++;
        end
    end
    sdg_link_sva i_sva (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .sclk(i_sdg_if[0].sclk),
        .chip_select_low(i_sdg_if[0].chip_select_low), .mosi(i_sdg_if[0].mosi),
        .miso_o(i_sdg_if[0].miso_o), .miso_oe(i_sdg_if[0].miso_oe));
    // 50 MHz system clock
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rnd(output logic [31:0] r);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        r = seed;
    endtask
    task automatic hw(input logic [1:0] a, input logic [31:0] d);
        h_wr <= 1'b1;
        h_addr <= a;
        h_wdata <= d;
        @(posedge i_clock);
        h_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic hr(input logic [1:0] a, output logic [31:0] d);
        h_rd <= 1'b1;
        h_addr <= a;
        @(posedge i_clock);
        h_rd <= 1'b0;
        #1 d = h_rdata;
        @(posedge i_clock);
    endtask
    // one datagram through the host; busy polled under a bound
    task automatic frame(input logic [7:0] ab, input logic [31:0] d, output logic [31:0] st,
        output logic [31:0] rx);
        hw(2'h0, {24'h0, ab});
        hw(2'h1, d);
        for (int k = 0; k < 400; k++) begin
            hr(2'h3, st);
            if (st[8] === 1'b0) break;
        end
        if (st[8] !== 1'b0) begin
            error_cnt++;
            stop_test();
        end
        repeat (6) @(posedge i_clock);
        hr(2'h2, rx);
        hr(2'h3, st);
    endtask
    // hand-made frame of n clocks, msb first, 160 ns link period
    task automatic bang(input int n, input logic [47:0] tx, output logic [47:0] rx);
        i_sdg_if[1].chip_select_low <= 1'b0;
        repeat (4) @(posedge i_clock);
        for (int k = n - 1; k >= 0; k--) begin
            i_sdg_if[1].sclk <= 1'b0;
            i_sdg_if[1].mosi <= tx[k];
            repeat (4) @(posedge i_clock);
            i_sdg_if[1].sclk <= 1'b1;
            repeat (4) @(posedge i_clock);
            rx[k] = i_sdg_if[1].miso_o;
        end
        i_sdg_if[1].chip_select_low <= 1'b1;
        i_sdg_if[1].mosi <= ~i_sdg_if[1].mosi;
        repeat (8) @(posedge i_clock);
    endtask
    // random datagrams with a sticky-flag pulse and a global state read among them
    initial begin
        logic [31:0] r, d, pd, st, rx;
        logic [47:0] bx;
        logic [7:0] ab, pa, est;
        int n;
        i_sdg_if[1].sclk = 1'b1;
        i_sdg_if[1].chip_select_low = 1'b1;
        i_sdg_if[1].mosi = 1'b0;
        est = 8'h00;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        for (int i = 0; i < 12; i++) begin
            rnd(r);
            rnd(d);
            lv <= r[3:0];
            ab = (i == 4) ? 8'h00 : (i == 6) ? 8'hFF : {r[8], r[15:9] | 7'h01};
            if (!ab[7]) d = 32'h0000_0000;
            if (i == 2) begin
                ev <= 3'h7;
                @(posedge i_clock);
                ev <= 3'h0;
            end
            n = g_dev[0].n;
            frame(ab, d, st, rx);
            chk("status", 40'(st[7:0]), 40'(est));
            if (i > 0) chk("echo", 40'(rx), 40'(pa[7] ? pd : rdv(pa[6:0])));
            chk("req count", 40'(g_dev[0].n - n), 40'h1);
            chk("request", {rq_w[0], rq_a[0], ab[7] ? rq_d[0] : 32'h0}, {ab, d});
            est = {1'b0, r[3:0], (i >= 2 && i <= 4) ? 3'h7 : 3'h0};
            chk("status byte", 40'(sb[0]), 40'(est));
            pa = ab;
            pd = d;
        end
        n = g_dev[1].n;
        bang(39, 48'h0000_A011_2233, bx);
        chk("short frame", 40'(g_dev[1].n - n), 40'h1 - 40'h1);
        bang(48, {8'hC3, 8'hA7, d}, bx);
        chk("daisy out", 40'(bx[7:0]), 40'hC3);
        chk("last forty", {rq_w[1], rq_a[1], rq_d[1]}, {8'hA7, d});
        bang(40, 48'h0005_0000_0000, bx);
        chk("chain echo", 40'(bx[31:0]), 40'(d));
        stop_test();
    end
endmodule
`default_nettype wire

// >>> hw/sdg_device.sv
// device end: link slave that turns datagrams into register requests
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: each datagram is forty bits, address then data
// R2: only active while chip select low
// R3: bit 39 high means write
// R4: always thirty-two data bits per register
// R5: read data returns in next datagram
// R6: after write, echo the written data
// R7: read leaves register alone, keeps address
// R8: host pads read data with dummies
// R9: always shift back, status byte first
// R10: status snapshot taken at each frame end
// R11: status bit map: reserved, stops, velocity
// R12: error and reset flags clear on read
// R13: sample on rise, drive after fall
// R14: host gives at least forty clocks
// R15: extra bits reappear forty clocks later
// R16: chip select rise latches the command
// R17: only last forty bits count
// R18: data right aligned, two's complement
// R19: clock idles high, mode three
// R20: link clock at most half system clock
// R21: output off when deselected; short frames dropped
// R22: one-cycle request to the register set
module sdg_device (
    // system
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // link
    sdg_if.dev link,
    // register set side
    output logic o_req_valid,
    output logic o_req_write,
    output logic [6:0] o_req_addr,
    output logic [31:0] o_req_wdata,
    input wire logic [31:0] i_rdata,
    // status sources
    input wire logic i_stop_left_axis_one,
    input wire logic i_stop_left_axis_two,
    input wire logic i_vel_reached_axis_one,
    input wire logic i_vel_reached_axis_two,
    input wire logic i_drv_err_axis_one,
    input wire logic i_drv_err_axis_two,
    input wire logic i_reset_event,
    output logic [7:0] o_link_status_byte
);
    logic [2:0] sck_s_q, cs_s_q;
    logic [1:0] mosi_s_q;
    logic [39:0] shift_q;
    logic [5:0] cnt_q;
    logic [7:0] status_q, sticky_q;
    logic miso_q, oe_q;
    logic [31:0] echo_q;
    logic sck_rise, sck_fall, cs_rise, cs_fall, cs_low, clr_sticky;

    // full frame ends: chip select rises after the counter saturated
    function automatic logic frame_complete(input logic rise, input logic [5:0] cnt);
        return rise && cnt == sdg_pkg::CNT_FULL;
    endfunction

    // timing budget, in system clock cycles:
    // - pin edges are seen two to three cycles late
    //   after the synchroniser, so the link clock
    //   needs a half period of at least two cycles
    // - miso moves three cycles after a link clock fall,
    //   well inside the low half of the clock
    // - the command pulse leaves three cycles after
    //   chip select rises; the echo word is captured
    //   one cycle after that
    // - the status snapshot is taken at the chip select
    //   rise, so a global state read returns its flags
    //   before they are cleared
    // - the daisy chain delay is exactly forty link clocks,
    //   since the same forty stages serve in and out
    // - the bit counter saturates at forty, so longer frames
    //   never wrap it back into the short-frame range
    // - reset holds the synchroniser stages at the idle
    //   levels, so no false edge follows reset
    // limitations:
    // - no glitch filter on the pins; a runt pulse on the
    //   link clock counts as an edge
    // - a frame shorter than forty clocks still refreshes
    //   the status snapshot, but makes no request
    // - the echo word is whatever the register set drives
    //   in the request cycle; it must answer at once
    // - status bit seven is tied low; the sticky word keeps
    //   its upper bits at zero for the same reason

    // two flops per input, third stage only for edge finding
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sck_s_q <= 3'h7;
            cs_s_q <= 3'h7;
            mosi_s_q <= 2'h0;
        end else begin
            sck_s_q <= {sck_s_q[1:0], link.sclk};
            cs_s_q <= {cs_s_q[1:0], link.chip_select_low};
            mosi_s_q <= {mosi_s_q[0], link.mosi};
        end
    end
    // edge detectors compare the second and third stages
    assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
    assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    assign cs_fall = ~cs_s_q[1] & cs_s_q[2];
    assign cs_low = ~cs_s_q[1]; // see R2

    // shift register: loaded at frame start, shifts link bits through forty stages
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            shift_q <= sdg_pkg::SHIFT_RESET;
        end else if (cs_fall) begin
            shift_q <= {status_q, echo_q}; // see R9 R5 R6
        end else if (cs_low && sck_rise) begin
            shift_q <= {shift_q[38:0], mosi_s_q[1]}; // see R13 R15 R17 R1
        end
    end

    // bit counter saturates; short frames are discarded
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
        end else if (cs_fall) begin
            cnt_q <= '0;
        end else if (cs_low && sck_rise && cnt_q != sdg_pkg::CNT_FULL) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // output changes at chip select fall and after falling link clock edges; msb leads
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            miso_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!cs_low) begin
            oe_q <= 1'b0; // see R21
        end else if (cs_fall) begin
            miso_q <= status_q[7];
            oe_q <= 1'b1;
        end else if (sck_fall) begin
            miso_q <= shift_q[39]; // see R13 R19
        end
    end
    assign link.miso_o = miso_q;
    assign link.miso_oe = oe_q;

    // one-cycle request at chip select rise, full frames only
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_req_valid <= 1'b0;
            o_req_write <= 1'b0;
            o_req_addr <= '0;
            o_req_wdata <= '0;
        end else begin
            o_req_valid <= frame_complete(cs_rise, cnt_q); // see R16 R21 R22
            if (frame_complete(cs_rise, cnt_q)) begin
                o_req_write <= shift_q[sdg_pkg::DIR_POS]; // see R3
                o_req_addr <= shift_q[38:32];
                o_req_wdata <= shift_q[31:0]; // see R4 R18
            end
        end
    end

    // echo word: write data for writes, register contents for reads
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            echo_q <= '0;
        end else if (o_req_valid) begin
            echo_q <= o_req_write ? o_req_wdata : i_rdata; // see R5 R6 R7
        end
    end

    // sticky flags; a new event beats the clear in the same cycle
    assign clr_sticky = o_req_valid && !o_req_write &&
        o_req_addr == sdg_pkg::GLOBAL_STATE_ADDR;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sticky_q <= sdg_pkg::STATUS_RESET;
        end else begin
            sticky_q[sdg_pkg::ST_DRV_ERR2] <= i_drv_err_axis_two |
                (sticky_q[sdg_pkg::ST_DRV_ERR2] & ~clr_sticky); // see R12
            sticky_q[sdg_pkg::ST_DRV_ERR1] <= i_drv_err_axis_one |
                (sticky_q[sdg_pkg::ST_DRV_ERR1] & ~clr_sticky);
            sticky_q[sdg_pkg::ST_RESET] <= i_reset_event |
                (sticky_q[sdg_pkg::ST_RESET] & ~clr_sticky);
            sticky_q[7:3] <= 5'h00;
        end
    end

    // snapshot at each frame end, served in the next frame
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            status_q <= sdg_pkg::STATUS_RESET;
        end else if (cs_rise) begin
            status_q[sdg_pkg::ST_RSVD] <= 1'b0; // see R10 R11
            status_q[sdg_pkg::ST_STOP_L2] <= i_stop_left_axis_two;
            status_q[sdg_pkg::ST_STOP_L1] <= i_stop_left_axis_one;
            status_q[sdg_pkg::ST_VEL2] <= i_vel_reached_axis_two;
            status_q[sdg_pkg::ST_VEL1] <= i_vel_reached_axis_one;
            status_q[2:0] <= sticky_q[2:0];
        end
    end
    assign o_link_status_byte = status_q;
endmodule
`default_nettype wire

// >>> hw/sdg_host.sv
// host end: link master that sends one forty-bit datagram per command
`timescale 1ns/1ps
`default_nettype none
module sdg_host (
    // system
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // command port
    input wire logic [1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // link
    sdg_if.host link
);
    typedef enum logic [2:0] {
        SDH_IDLE = 3'b001,
        SDH_SHIFT = 3'b010,
        SDH_GAP = 3'b100
    } sdh_state_e;
    sdh_state_e state_q;
    logic [39:0] tx_q, rx_q;
    logic [7:0] div_q;
    logic [6:0] edges_q;
    logic sclk_q, cs_q, mosi_q, busy;
    logic [1:0] miso_s_q;
    logic [7:0] cmd_addr_q;
    logic tick;

    // register map: 0 address byte, 1 data and go, 2 rx data, 3 rx status/busy
    assign busy = state_q != SDH_IDLE;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cmd_addr_q <= 8'h00;
        end else if (i_wr && i_addr == 2'h0) begin
            cmd_addr_q <= i_wdata[7:0]; // see R3
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                2'h0: o_rdata <= {24'h000000, cmd_addr_q};
                2'h1: o_rdata <= tx_q[31:0];
                2'h2: o_rdata <= rx_q[31:0];
                2'h3: o_rdata <= {23'h000000, busy, rx_q[39:32]};
            endcase
        end
    end

    // divider: slow enable every half link period
    assign tick = div_q == sdg_pkg::HALF_CNT - 8'h01;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || state_q == SDH_IDLE) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01; // see R20
        end
    end

    // incoming data bit from the device, two flops
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            miso_s_q <= 2'h0;
        end else begin
            miso_s_q <= {miso_s_q[0], link.miso_o & link.miso_oe};
        end
    end

    // frame sequencer: eighty half periods, clock idles high
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_q <= SDH_IDLE;
            sclk_q <= 1'b1;
            cs_q <= 1'b1;
            mosi_q <= 1'b0;
            edges_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
        end else begin
            unique case (state_q)
                SDH_IDLE: begin
                    if (i_wr && i_addr == 2'h1) begin
                        // a read carries zero data; see R8
                        tx_q <= {cmd_addr_q, cmd_addr_q[7] ? i_wdata : 32'h0000_0000}; // see R1
                        cs_q <= 1'b0; // see R2
                        edges_q <= '0;
                        state_q <= SDH_SHIFT;
                    end
                end
                SDH_SHIFT: begin
                    if (tick) begin
                        edges_q <= edges_q + 7'h01;
                        if (!edges_q[0]) begin
                            sclk_q <= 1'b0; // see R19
                            mosi_q <= tx_q[39];
                            tx_q <= {tx_q[38:0], 1'b0};
                            // round trip through both synchronisers outlasts a half period,
                            // so the bit launched at the previous fall is taken here; see R13
                            if (edges_q != 7'h00) begin
                                rx_q <= {rx_q[38:0], miso_s_q[1]};
                            end
                        end else begin
                            sclk_q <= 1'b1;
                            if (edges_q == 7'h4F) begin
                                state_q <= SDH_GAP; // see R14
                            end
                        end
                    end
                end
                SDH_GAP: begin
                    if (tick) begin
                        if (!cs_q) begin
                            rx_q <= {rx_q[38:0], miso_s_q[1]}; // last bit of the frame
                        end
                        cs_q <= 1'b1;
                        state_q <= cs_q ? SDH_IDLE : SDH_GAP;
                    end
                end
                default: state_q <= SDH_IDLE;
            endcase
        end
    end
    assign link.sclk = sclk_q;
    assign link.chip_select_low = cs_q;
    assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// >>> hw/sdg_if.sv
// link wires between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface sdg_if;
    logic sclk;
    logic chip_select_low;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    modport host (output sclk, output chip_select_low, output mosi, input miso_o, input miso_oe);
    modport dev (input sclk, input chip_select_low, input mosi, output miso_o, output miso_oe);
endinterface
`default_nettype wire

// >>> hw/sdg_pkg.sv
// shared constants for the serial datagram link
package sdg_pkg;
    localparam int DGRAM_BITS = 40;
    localparam int DATA_BITS = 32;
    localparam int ADDR_BITS = 7;
    localparam int DIR_POS = 39;
    localparam int STAT_MSB = 39;
    localparam int STAT_LSB = 32;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h28;
    // status byte positions
    localparam int ST_RSVD = 7;
    localparam int ST_STOP_L2 = 6;
    localparam int ST_STOP_L1 = 5;
    localparam int ST_VEL2 = 4;
    localparam int ST_VEL1 = 3;
    localparam int ST_DRV_ERR2 = 2;
    localparam int ST_DRV_ERR1 = 1;
    localparam int ST_RESET = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // address of the global state register; its read clears the sticky flags
    localparam logic [6:0] GLOBAL_STATE_ADDR = 7'h00;
    localparam logic [39:0] SHIFT_RESET = 40'h00_0000_0000;
    // host divider: half period of the link clock in system cycles
    localparam int HALF_PERIOD = 4;
    localparam logic [7:0] HALF_CNT = 8'h04;
endpackage
